// ==== design/irq_entry_defines.svh ====
// constants for the interrupt entry and return unit
`ifndef IRQ_ENTRY_DEFINES_SVH
`define IRQ_ENTRY_DEFINES_SVH
`define ADDR_STATUS 32'h0000_0000
`define ADDR_CONTROL 32'h0000_0004
`define ADDR_FLAGS 32'h0000_0008
`define ADDR_ENABLE 32'h0000_000C
`define ADDR_SP 32'h0000_0010
`define ADDR_STATE 32'h0000_0014
`define ADDR_BOOT_START 32'h0000_0018
`define GIE_BIT 7
`define CTRL_VECTOR_SELECT_BIT 1
`define CTRL_BOOT_RESET_BIT 0
`define CTRL_APPLOCK_BIT 2
`define CTRL_BOOTLOCK_BIT 3
`define ENTRY_CYCLES 4
`define WAKE_EXTRA_CYCLES 4
`define RETURN_CYCLES 4
`define SP_RESET 16'h08FF
`define STATUS_RESET 8'h00
`endif

// ==== design/irq_entry_pkg.sv ====
// types for the interrupt entry and return unit
package irq_entry_pkg;
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_WAKE = 3'b001,
      ST_ENTRY = 3'b010,
      ST_RETURN = 3'b011,
      ST_AFTER = 3'b100
   } seq_state_t;
endpackage

// ==== design/irq_priority_pick.sv ====
// picks the lowest-numbered active request
`timescale 1ns/1ps
module irq_priority_pick #(
   parameter int N = 8,
   parameter int W = 3
) (
   // requests
   input wire logic [N-1:0] req_in,
   // answer
   output logic any_out,
   output logic [W-1:0] index_out
);
   logic [W-1:0] idx [N:0];
   genvar i;
   assign idx[N] = '0;
   generate
      for (i = N - 1; i >= 0; i--) begin : g_pick
         assign idx[i] = req_in[i] ? W'(i) : idx[i+1];
      end
   endgenerate
   assign any_out = |req_in;
   assign index_out = idx[0];
   initial begin
      if (N < 1 || (1 << W) < N) begin
         $error("bad priority width");
      end
   end
endmodule // irq_priority_pick

// ==== design/irq_flag_bank.sv ====
// pending flags for flag-type sources plus level sources
`timescale 1ns/1ps
module irq_flag_bank #(
   parameter int N = 8
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // sources
   input wire logic [N-1:0] event_in,
   input wire logic [N-1:0] level_type_in,
   // clears
   input wire logic [N-1:0] sw_clear_in,
   input wire logic [N-1:0] hw_clear_in,
   // state
   output logic [N-1:0] pending_out
);
   logic [N-1:0] flag_reg;
   logic [N-1:0] flag_next;
   // set wins over a clear in the same cycle
   assign flag_next = (flag_reg & ~sw_clear_in & ~hw_clear_in) |
                      (event_in & ~level_type_in);
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         flag_reg <= '0;
      end else begin
         flag_reg <= flag_next;
      end
   end
   // level sources request only while present
   assign pending_out = (flag_reg & ~level_type_in) |
                        (event_in & level_type_in);
endmodule // irq_flag_bank

// ==== design/cpu_interrupt_entry_return.sv ====
// interrupt acceptance, entry and return sequencer with ahb-lite registers
`timescale 1ns/1ps
`include "irq_entry_defines.svh"
// How it works
// - a source is taken only when its enable and global enable are one
// - lower vector number wins; reset first, then external request zero
// - vectors sit low; select bit moves them, fuse moves reset vector
// - lock bits suppress interrupts depending on program counter
// - accepting an interrupt clears the global enable
// - return from interrupt sets the global enable again
// - vectoring clears the taken source's pending flag
// - writing one clears a flag, zero leaves it
// - flags set while disabled stay until enabled or cleared
// - flags held while global is off are served by priority later
// - level sources request only while their condition is present
// - after return one main instruction runs before another entry
// - status register is neither saved nor restored by hardware
// - clear-global takes effect at once, same-cycle requests too
// - one instruction runs after set-global before any entry
// - entry takes four cycles, pushes program counter, then vector
// - a multi-cycle instruction finishes before entry begins
// - waking from sleep adds four cycles to entry
// - return takes four cycles, pops two bytes, stack pointer plus two
// - one clock, no division; one-cycle alu register operation
// - program counter width is 11 to 14 bits
// - entry push lowers the stack pointer by two
// - global enable is bit 7 of the status register
module cpu_interrupt_entry_return
   import irq_entry_pkg::*;
#(
   parameter int NUM_SOURCES = 8,
   parameter int PC_WIDTH = 14
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // ahb-lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // peripheral sources
   input wire logic [NUM_SOURCES-1:0] source_event_in,
   input wire logic [NUM_SOURCES-1:0] source_level_type_in,
   // instruction sequencer
   input wire logic insn_boundary_in,
   input wire logic insn_is_sei_in,
   input wire logic insn_is_cli_in,
   input wire logic insn_is_irq_return_in,
   input wire logic sleeping_in,
   input wire logic [PC_WIDTH-1:0] program_counter_in,
   output logic irq_entry_busy_out,
   output logic irq_return_busy_out,
   output logic vector_load_out,
   output logic [PC_WIDTH-1:0] vector_addr_out,
   output logic [PC_WIDTH-1:0] reset_vector_out,
   output logic stack_write_out,
   output logic [15:0] stack_addr_out,
   output logic [7:0] stack_wdata_out,
   output logic stack_read_out,
   input wire logic [7:0] stack_rdata_in,
   output logic [PC_WIDTH-1:0] return_pc_out,
   output logic return_pc_valid_out,
   output logic [15:0] stack_pointer_out,
   output logic global_enable_out
);
   localparam int IW = (NUM_SOURCES > 1) ? $clog2(NUM_SOURCES) : 1;
   initial begin
      if (PC_WIDTH < 11 || PC_WIDTH > 14 || NUM_SOURCES < 2 ||
          NUM_SOURCES > 32) begin
         $error("unsupported parameter values");
      end
   end

   // registers
   logic [7:0] status_reg;
   logic [7:0] status_next;
   logic [3:0] control_reg;
   logic [NUM_SOURCES-1:0] enable_reg;
   logic [15:0] sp_reg;
   logic [15:0] sp_next;
   logic [PC_WIDTH-1:0] boot_start_reg;
   seq_state_t state_reg;
   seq_state_t state_next;
   logic [2:0] count_reg;
   logic [2:0] count_next;
   logic hold_off_reg;
   logic [IW-1:0] taken_reg;
   logic [PC_WIDTH-1:0] saved_pc_reg;
   logic [7:0] pop_low_reg;
   logic [PC_WIDTH-1:0] ret_pc_reg;
   logic ret_valid_reg;
   // bus pipeline
   logic wr_pend_reg;
   logic [31:0] wr_addr_reg;
   logic [31:0] rdata_reg;

   // pending flags
   logic [NUM_SOURCES-1:0] pending;
   logic [NUM_SOURCES-1:0] sw_clear;
   logic [NUM_SOURCES-1:0] hw_clear;
   irq_flag_bank #(.N(NUM_SOURCES)) u_flags (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .event_in(source_event_in),
      .level_type_in(source_level_type_in),
      .sw_clear_in(sw_clear),
      .hw_clear_in(hw_clear),
      .pending_out(pending)
   );

   // acceptance gating
   wire gie = status_reg[`GIE_BIT];
   wire [NUM_SOURCES-1:0] active = pending & enable_reg;
   wire in_boot = program_counter_in >= boot_start_reg;
   wire lock_block = (control_reg[`CTRL_APPLOCK_BIT] & ~in_boot) |
                     (control_reg[`CTRL_BOOTLOCK_BIT] & in_boot);
   wire any_active;
   wire [IW-1:0] pick;
   irq_priority_pick #(.N(NUM_SOURCES), .W(IW)) u_pick (
      .req_in(active),
      .any_out(any_active),
      .index_out(pick)
   );
   // cli in this boundary blocks at once; sei or return hold off one insn
   wire take = (state_reg == ST_RUN) && insn_boundary_in && any_active &&
               gie && !insn_is_cli_in && !hold_off_reg &&
               !lock_block;
   wire start_ret = (state_reg == ST_RUN) && insn_boundary_in &&
                    insn_is_irq_return_in && !take;

   // vector placement
   wire [PC_WIDTH-1:0] ivec_base = control_reg[`CTRL_VECTOR_SELECT_BIT] ?
                                   boot_start_reg : '0;
   assign reset_vector_out = control_reg[`CTRL_BOOT_RESET_BIT] ?
                             boot_start_reg : '0;
   // vector n+1 at two words each, slot zero is reset
   wire [PC_WIDTH-1:0] vec_off = PC_WIDTH'({taken_reg, 1'b0}) +
                                 PC_WIDTH'(2);

   // sequencer
   wire cnt_done = (count_reg == 3'(`ENTRY_CYCLES - 1));
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      case (state_reg)
         ST_RUN: begin
            count_next = 3'h0;
            if (take) begin
               state_next = sleeping_in ? ST_WAKE : ST_ENTRY;
            end else if (start_ret) begin
               state_next = ST_RETURN;
            end
         end
         ST_WAKE: begin
            count_next = count_reg + 3'h1;
            if (count_reg == 3'(`WAKE_EXTRA_CYCLES - 1)) begin
               state_next = ST_ENTRY;
               count_next = 3'h0;
            end
         end
         ST_ENTRY: begin
            count_next = count_reg + 3'h1;
            if (cnt_done) begin
               state_next = ST_RUN;
            end
         end
         ST_RETURN: begin
            count_next = count_reg + 3'h1;
            if (count_reg == 3'(`RETURN_CYCLES - 1)) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   // stack traffic: push low byte then high byte, pop in reverse
   wire push_lo = (state_reg == ST_ENTRY) && (count_reg == 3'h0);
   wire push_hi = (state_reg == ST_ENTRY) && (count_reg == 3'h1);
   wire pop_hi = (state_reg == ST_RETURN) && (count_reg == 3'h0);
   wire pop_lo = (state_reg == ST_RETURN) && (count_reg == 3'h1);
   wire [15:0] pc_word = 16'(saved_pc_reg);
   assign stack_write_out = push_lo | push_hi;
   assign stack_read_out = pop_hi | pop_lo;
   assign stack_addr_out = push_lo ? sp_reg :
                           push_hi ? sp_reg - 16'h0001 :
                           pop_hi ? sp_reg + 16'h0001 :
                           sp_reg + 16'h0002;
   assign stack_wdata_out = push_lo ? pc_word[7:0] : pc_word[15:8];

   // bus decode
   wire bus_req = hsel_in && hready_in && htrans_in[1];
   wire [NUM_SOURCES-1:0] wdat_n = hwdata_in[NUM_SOURCES-1:0];
   wire w_status = wr_pend_reg && (wr_addr_reg == `ADDR_STATUS);
   wire w_control = wr_pend_reg && (wr_addr_reg == `ADDR_CONTROL);
   wire w_flags = wr_pend_reg && (wr_addr_reg == `ADDR_FLAGS);
   wire w_enable = wr_pend_reg && (wr_addr_reg == `ADDR_ENABLE);
   wire w_sp = wr_pend_reg && (wr_addr_reg == `ADDR_SP);
   wire w_boot = wr_pend_reg && (wr_addr_reg == `ADDR_BOOT_START);
   assign sw_clear = w_flags ? wdat_n : '0;
   assign hw_clear = (state_reg == ST_ENTRY && cnt_done) ?
                     (NUM_SOURCES'(1) << taken_reg) & ~source_level_type_in :
                     '0;
   wire [31:0] rd_mux =
      (haddr_in == `ADDR_STATUS) ? {24'h0, status_reg} :
      (haddr_in == `ADDR_CONTROL) ? {28'h0, control_reg} :
      (haddr_in == `ADDR_FLAGS) ? 32'(pending) :
      (haddr_in == `ADDR_ENABLE) ? 32'(enable_reg) :
      (haddr_in == `ADDR_SP) ? {16'h0, sp_reg} :
      (haddr_in == `ADDR_STATE) ? {29'h0, state_reg} :
      (haddr_in == `ADDR_BOOT_START) ? 32'(boot_start_reg) : 32'h0;

   // status: only the global enable is touched by hardware
   always_comb begin
      status_next = status_reg;
      if (w_status) begin
         status_next = hwdata_in[7:0];
      end
      if (insn_boundary_in && insn_is_sei_in) begin
         status_next[`GIE_BIT] = 1'b1;
      end
      if (insn_boundary_in && insn_is_cli_in) begin
         status_next[`GIE_BIT] = 1'b0;
      end
      if (take) begin
         status_next[`GIE_BIT] = 1'b0;
      end
      if (state_reg == ST_RETURN &&
          count_reg == 3'(`RETURN_CYCLES - 1)) begin
         status_next[`GIE_BIT] = 1'b1;
      end
   end
   assign sp_next = w_sp ? hwdata_in[15:0] :
                    push_hi ? sp_reg - 16'h0002 :
                    pop_lo ? sp_reg + 16'h0002 : sp_reg;

   // one clock drives everything, no divider
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         status_reg <= `STATUS_RESET;
         control_reg <= 4'h0;
         enable_reg <= '0;
         sp_reg <= `SP_RESET;
         boot_start_reg <= '0;
         state_reg <= ST_RUN;
         count_reg <= 3'h0;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 32'h0;
         rdata_reg <= 32'h0;
      end else begin
         status_reg <= status_next;
         if (w_control) begin
            control_reg <= hwdata_in[3:0];
         end
         if (w_enable) begin
            enable_reg <= wdat_n;
         end
         sp_reg <= sp_next;
         if (w_boot) begin
            boot_start_reg <= hwdata_in[PC_WIDTH-1:0];
         end
         state_reg <= state_next;
         count_reg <= count_next;
         wr_pend_reg <= bus_req && hwrite_in;
         wr_addr_reg <= haddr_in;
         if (bus_req && !hwrite_in) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         hold_off_reg <= 1'b0;
         taken_reg <= '0;
         saved_pc_reg <= '0;
         pop_low_reg <= 8'h00;
         ret_pc_reg <= '0;
         ret_valid_reg <= 1'b0;
      end else begin
         if (insn_boundary_in && state_reg == ST_RUN) begin
            hold_off_reg <= insn_is_sei_in;
         end else if (state_reg == ST_RETURN) begin
            hold_off_reg <= 1'b1;
         end
         if (take) begin
            taken_reg <= pick;
            saved_pc_reg <= program_counter_in;
         end
         if (pop_hi) begin
            pop_low_reg <= stack_rdata_in;
         end
         ret_valid_reg <= pop_lo;
         if (pop_lo) begin
            ret_pc_reg <= PC_WIDTH'({pop_low_reg, stack_rdata_in});
         end
      end
   end

   // sequencer outputs
   assign irq_entry_busy_out = (state_reg == ST_WAKE) ||
                               (state_reg == ST_ENTRY);
   assign irq_return_busy_out = (state_reg == ST_RETURN);
   assign vector_load_out = (state_reg == ST_ENTRY) && cnt_done;
   assign vector_addr_out = ivec_base + vec_off;
   assign return_pc_out = ret_pc_reg;
   assign return_pc_valid_out = ret_valid_reg;
   assign stack_pointer_out = sp_reg;
   assign global_enable_out = gie;
   assign hrdata_out = rdata_reg;
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
endmodule // cpu_interrupt_entry_return

// ==== testbench/irq_entry_properties.sv ====
// timing checker for the interrupt entry and return unit
`timescale 1ns/1ps
module irq_entry_properties (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // sequencer side
   input wire logic insn_boundary_in,
   input wire logic insn_is_sei_in,
   input wire logic insn_is_cli_in,
   input wire logic sleeping_in,
   input wire logic irq_entry_busy_out,
   input wire logic irq_return_busy_out,
   input wire logic vector_load_out,
   input wire logic stack_write_out,
   input wire logic stack_read_out,
   input wire logic [15:0] stack_addr_out,
   input wire logic [15:0] stack_pointer_out,
   input wire logic return_pc_valid_out,
   input wire logic global_enable_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);
   wire logic idle = !irq_entry_busy_out && !irq_return_busy_out;
   a_entry_time: assert property (
      $rose(irq_entry_busy_out) && !$past(sleeping_in) |-> ##3 vector_load_out)
      else $error("entry length wrong");
   a_wake_time: assert property (
      $rose(irq_entry_busy_out) && $past(sleeping_in) |-> ##7 vector_load_out)
      else $error("wake entry length wrong");
   a_gie_clear: assert property (
      $rose(irq_entry_busy_out) |-> $past(global_enable_out) && !global_enable_out)
      else $error("global enable wrong at entry");
   a_push_order: assert property (
      $rose(stack_write_out) |-> stack_addr_out == stack_pointer_out ##1
      stack_write_out && stack_addr_out == $past(stack_addr_out) - 16'h0001)
      else $error("push order wrong");
   a_sp_entry: assert property (
      vector_load_out |-> stack_pointer_out == $past(stack_pointer_out, 4) - 16'h0002)
      else $error("stack pointer not lowered by two");
   a_return_time: assert property (
      $rose(irq_return_busy_out) |-> ##2 return_pc_valid_out ##2 global_enable_out)
      else $error("return timing wrong");
   a_pop_order: assert property (
      $rose(stack_read_out) |-> stack_addr_out == stack_pointer_out + 16'h0001 ##1
      stack_read_out && stack_addr_out == $past(stack_addr_out) + 16'h0001)
      else $error("pop order wrong");
   a_cli_block: assert property (
      insn_boundary_in && insn_is_cli_in && idle |=> !irq_entry_busy_out)
      else $error("entry after clear of global enable");
   a_sei_holdoff: assert property (
      insn_boundary_in && insn_is_sei_in && idle |=> !irq_entry_busy_out)
      else $error("entry at set of global enable");
   a_after_return: assert property (
      $fell(irq_return_busy_out) |-> ##1 !irq_entry_busy_out)
      else $error("entry straight after return");
endmodule // irq_entry_properties
bind cpu_interrupt_entry_return irq_entry_properties irq_entry_properties_inst (
   .core_clk_in, .reset_n_in, .insn_boundary_in, .insn_is_sei_in,
   .insn_is_cli_in, .sleeping_in, .irq_entry_busy_out, .irq_return_busy_out,
   .vector_load_out, .stack_write_out, .stack_read_out, .stack_addr_out,
   .stack_pointer_out, .return_pc_valid_out, .global_enable_out);

// ==== testbench/irq_stack_model.sv ====
// stack memory behind the push and pop cycles
`timescale 1ns/1ps
module irq_stack_model (
   // clock
   input wire logic core_clk_in,
   // stack port
   input wire logic stack_write_in,
   input wire logic stack_read_in,
   input wire logic [15:0] stack_addr_in,
   input wire logic [7:0] stack_wdata_in,
   output logic [7:0] stack_rdata_out
);
   logic [7:0] mem [0:4095];
   logic [7:0] last_reg = 8'h00;
   always @(posedge core_clk_in) begin
      if (stack_write_in) mem[stack_addr_in[11:0]] <= stack_wdata_in;
      if (stack_read_in) last_reg <= mem[stack_addr_in[11:0]];
   end
   // outside a pop the data is stale and inverted
   assign stack_rdata_out = stack_read_in ? mem[stack_addr_in[11:0]] : ~last_reg;
endmodule // irq_stack_model

// ==== testbench/tb_top.sv ====
// self-checking bench for the interrupt entry and return unit
`timescale 1ns/1ps
`include "irq_entry_defines.svh"
module tb_top;
   import irq_entry_pkg::*;
   typedef struct packed {logic [31:0] a; logic [31:0] e;} row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, r;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [7:0] ev = 8'h00;
   logic [7:0] lvl = 8'h00;
   logic bnd = 1'b0, sei = 1'b0, cli = 1'b0, rtn = 1'b0, slp = 1'b0;
   logic [13:0] pc = 14'h1234;
   logic [13:0] vaddr, rvec, rpc;
   logic [15:0] saddr, sp;
   logic [7:0] swd, srd;
   logic hready, ebusy, rbusy, vload, swr, srdq, rpcv, gie;
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   row_t rows [8] = '{'{`ADDR_STATUS, 32'h0}, '{`ADDR_CONTROL, 32'h0},
      '{`ADDR_FLAGS, 32'h0}, '{`ADDR_ENABLE, 32'h0},
      '{`ADDR_SP, {16'h0, `SP_RESET}}, '{`ADDR_STATE, {29'h0, ST_RUN}},
      '{`ADDR_BOOT_START, 32'h0}, '{32'h40, 32'h0}};
   cpu_interrupt_entry_return cpu_interrupt_entry_return_inst (
      .core_clk_in(clk), .reset_n_in(rst_n), .hsel_in(1'b1),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
      .source_event_in(ev), .source_level_type_in(lvl),
      .insn_boundary_in(bnd), .insn_is_sei_in(sei), .insn_is_cli_in(cli),
      .insn_is_irq_return_in(rtn), .sleeping_in(slp), .program_counter_in(pc),
      .irq_entry_busy_out(ebusy), .irq_return_busy_out(rbusy),
      .vector_load_out(vload), .vector_addr_out(vaddr),
      .reset_vector_out(rvec), .stack_write_out(swr),
      .stack_addr_out(saddr), .stack_wdata_out(swd), .stack_read_out(srdq),
      .stack_rdata_in(srd), .return_pc_out(rpc), .return_pc_valid_out(rpcv),
      .stack_pointer_out(sp), .global_enable_out(gie));
   irq_stack_model irq_stack_model_inst (.core_clk_in(clk),
      .stack_write_in(swr), .stack_read_in(srdq), .stack_addr_in(saddr),
      .stack_wdata_in(swd), .stack_rdata_out(srd));
   always #2.5 clk = ~clk;
   task automatic final_report;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         final_report;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(r, e);
   endtask
   task automatic step(input logic s, input logic c, input logic t);
      bnd <= 1'b1;
      sei <= s;
      cli <= c;
      rtn <= t;
      @(posedge clk);
      bnd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic await(input logic ret);
      for (int i = 0; i < 30 && (ret ? rpcv : vload) !== 1'b1; i++)
         @(posedge clk);
      chk(ret ? rpcv : vload, 1'b1);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (rows[i]) rdchk(rows[i].a, rows[i].e);
      $display("test reset values done");
      ev <= 8'h04;
      step(0, 0, 0);
      ev <= 8'h00;
      rdchk(`ADDR_FLAGS, 32'h04);
      xfer(1'b1, `ADDR_FLAGS, 32'h0);
      rdchk(`ADDR_FLAGS, 32'h04);
      xfer(1'b1, `ADDR_FLAGS, 32'h04);
      rdchk(`ADDR_FLAGS, 32'h00);
      xfer(1'b1, `ADDR_ENABLE, 32'h0A);
      ev <= 8'h0A;
      step(0, 0, 0);
      ev <= 8'h00;
      chk(ebusy, 1'b0);
      xfer(1'b1, `ADDR_STATUS, 32'h81);
      step(0, 0, 0);
      await(1'b0);
      chk(vaddr, 14'h0004);
      chk(gie, 1'b0);
      chk(sp, 16'h08FD);
      chk({irq_stack_model_inst.mem[12'h8FE],
         irq_stack_model_inst.mem[12'h8FF]}, 16'h1234);
      rdchk(`ADDR_FLAGS, 32'h08);
      xfer(1'b1, `ADDR_STATUS, 32'h05);
      step(0, 0, 1);
      await(1'b1);
      chk(rpc, 14'h1234);
      repeat (3) @(posedge clk);
      chk(gie, 1'b1);
      chk(sp, 16'h08FF);
      rdchk(`ADDR_STATUS, 32'h85);
      step(0, 0, 0);
      chk(ebusy, 1'b0);
      step(0, 0, 0);
      await(1'b0);
      chk(vaddr, 14'h0008);
      step(0, 0, 1);
      await(1'b1);
      $display("test entry and return done");
      xfer(1'b1, `ADDR_BOOT_START, 32'h100);
      xfer(1'b1, `ADDR_CONTROL, 32'h03);
      xfer(1'b1, `ADDR_ENABLE, 32'h01);
      chk(rvec, 14'h0100);
      step(0, 0, 0);
      ev <= 8'h01;
      slp <= 1'b1;
      step(0, 0, 0);
      ev <= 8'h00;
      step(0, 0, 0);
      await(1'b0);
      chk(vaddr, 14'h0102);
      slp <= 1'b0;
      step(0, 0, 1);
      await(1'b1);
      $display("test sleep and relocation done");
      lvl <= 8'h10;
      ev <= 8'h10;
      step(0, 0, 0);
      ev <= 8'h00;
      xfer(1'b1, `ADDR_ENABLE, 32'h10);
      step(0, 0, 0);
      chk(ebusy, 1'b0);
      ev <= 8'h10;
      step(0, 1, 0);
      chk(ebusy, 1'b0);
      chk(gie, 1'b0);
      step(1, 0, 0);
      step(0, 0, 0);
      chk(ebusy, 1'b0);
      step(0, 0, 0);
      await(1'b0);
      chk(vaddr, 14'h010A);
      step(0, 0, 1);
      await(1'b1);
      xfer(1'b1, `ADDR_CONTROL, 32'h04);
      pc <= 14'h0050;
      step(0, 0, 0);
      step(0, 0, 0);
      chk(ebusy, 1'b0);
      pc <= 14'h0200;
      step(0, 0, 0);
      await(1'b0);
      chk(vaddr, 14'h000A);
      $display("test level, mask and lock done");
      final_report;
   end
endmodule // tb_top
